// File: ppc_pix_src.sv
// ppc_pix_src: pixel source model with colour tables for the output stage
// assumes: shares clk_in with ppc_top; colours answer LUT_LAT clocks after index
`timescale 1ns/10ps
module ppc_pix_src
    import ppc_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        vis_en_in,
    output logic      [7:0]  idx_out,
    output logic             sel_out,
    output logic             sync_out,
    output logic             blank_out,
    output logic      [1:0]  ovl_out,
    output logic      [23:0] pseudo_rgb_out,
    output logic      [23:0] true_rgb_out
);
    logic [7:0] cnt;     // pixel counter behind every field
    logic [7:0] field;   // true-colour field of the current pixel
    logic [7:0] idx_d1;  // index one clock back, table input
    logic [7:0] fld_d1;  // true field one clock back, table input

    // pixel fields; a zero index every eighth pixel exercises the fallbacks
    always_ff @(posedge clk_in) begin
        cnt       <= rst_in ? 8'h00 : cnt + 8'h01;
        idx_out   <= (cnt[2:0] == 3'h0) ? 8'h00 : cnt * 8'h35;
        field     <= cnt ^ 8'h6c;
        sel_out   <= cnt[1] ^ cnt[3];
        sync_out  <= cnt[0] ^ cnt[3] ^ cnt[5];
        ovl_out   <= {cnt[1] ^ cnt[4], cnt[0] ^ cnt[2]};
        // blanked while the bench holds flyback, plus short gaps in a line
        blank_out <= ~vis_en_in | (cnt[3:1] == 3'h5);
    end

    // two-stage table lookup, so colours land two clocks after the index
    always_ff @(posedge clk_in) begin
        idx_d1         <= idx_out;
        fld_d1         <= field;
        pseudo_rgb_out <= {idx_d1 ^ 8'h3c, idx_d1 + 8'h11, ~idx_d1};
        true_rgb_out   <= {fld_d1, fld_d1 ^ 8'ha5, fld_d1 + 8'h07};
    end
endmodule

// File: ppc_pkg.sv
// ppc_pkg: constants and types for the pan, composite and signature block
// assumes: imported whole by every design module of the block; the ppc_sig_if interface does not import it
package ppc_pkg;
    // pixel path latency through the colour tables, in video clocks
    localparam int          LUT_LAT    = 2;
    // largest programmable pan delay, in pixels
    localparam int          PAN_MAX    = 7;
    // sync/blank/overlay shift depth: table latency plus the largest pan
    localparam int          SB_DEPTH   = LUT_LAT + PAN_MAX;
    // register word offsets on the local register port
    localparam logic [1:0]  ADDR_PAN   = 2'h0;
    localparam logic [1:0]  ADDR_MERGE = 2'h1;
    localparam logic [1:0]  ADDR_SIG   = 2'h2;
    localparam logic [1:0]  ADDR_STAT  = 2'h3;
    // field positions in the pan register
    localparam int          PAN_OVL_BIT = 3;
    // values after reset
    localparam logic [3:0]  PAN_RST    = 4'h0;
    localparam logic [1:0]  MERGE_RST  = 2'h0;
    // signature register: start value, feedback taps, top bit
    localparam logic [23:0] SIG_INIT   = 24'hffffff;
    localparam logic [23:0] SIG_TAP    = 24'h610000;
    localparam int          SIG_TOP    = 23;
    // compositing modes
    localparam logic [1:0]  MERGE_KEY_SEL  = 2'h0;
    localparam logic [1:0]  MERGE_KEY_ONLY = 2'h1;
    localparam logic [1:0]  MERGE_SEL_ONLY = 2'h2;
    localparam logic [1:0]  MERGE_PSEUDO   = 2'h3;
    // configuration age at which checks treat settings as settled
    localparam logic [3:0]  CFG_SETTLED = 4'ha;
    // signature read pointer
    typedef enum logic [1:0] {CH_RED, CH_GREEN, CH_BLUE} ppc_chan_t;
endpackage

// File: ppc_sig_acc.sv
// ppc_sig_acc: 24-bit feedback signature over pairs of visible bytes
// assumes: one instance per colour channel, fed through ppc_sig_if
`timescale 1ns/10ps
module ppc_sig_acc
    import ppc_pkg::*;
(
    input  wire logic clk_in,
    input  wire logic rst_in,
    ppc_sig_if.sink   sig
);
    logic [7:0]  low_byte;  // earlier byte of the current pair
    logic        have_low;  // a pair is half collected
    logic [23:0] sum;       // signature state
    logic [23:0] next_sum;  // state after one step
    logic [23:0] mixed;     // state with the pair folded in
    logic [23:0] fed;       // mixed with taps applied

    // one step: fold in the word, then shift with feedback on a clear top bit
    always_comb begin
        mixed = sum ^ {8'h00, sig.data, low_byte};
        fed   = mixed ^ SIG_TAP;
        if (mixed[SIG_TOP] == 1'b0) begin
            next_sum = {fed[22:0], 1'b1};
        end else begin
            next_sum = {mixed[22:0], 1'b0};
        end
    end

    // pair collection and update; a frame restart drops any half pair
    always_ff @(posedge clk_in) begin
        if (rst_in || sig.clear) begin
            sum      <= SIG_INIT;
            have_low <= 1'b0;
            low_byte <= 8'h00;
        end else if (sig.take) begin
            if (!have_low) begin
                low_byte <= sig.data;
                have_low <= 1'b1;
            end else begin
                sum      <= next_sum;
                have_low <= 1'b0;
            end
        end
    end

    assign sig.sum = sum;

    sig_clear_a: assert property (@(posedge clk_in) disable iff (rst_in)
        sig.clear |=> sum == SIG_INIT)
        else $error("signature not restarted after frame start");
    blank_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (!sig.take && !sig.clear) |=> $stable(sum))
        else $error("signature moved without a visible byte");
    pair_first_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (sig.take && !sig.clear && !have_low) |=> $stable(sum) && have_low)
        else $error("signature stepped on the first byte of a pair");
    pair_cover_c: cover property (@(posedge clk_in) disable iff (rst_in)
        sig.take && have_low && !sig.clear);
endmodule

// File: ppc_sig_if.sv
// ppc_sig_if: one colour channel's byte feed into its signature accumulator
// assumes: src end in the top module, sink end in ppc_sig_acc, same clock
`timescale 1ns/10ps
interface ppc_sig_if;
    logic        clear;  // restart the frame signature
    logic        take;   // data holds a visible byte this cycle
    logic [7:0]  data;   // channel byte as sent to the converter
    logic [23:0] sum;    // running signature
    modport src  (output clear, output take, output data, input sum);
    modport sink (input clear, input take, input data, output sum);
endinterface

// File: ppc_top.sv
// ppc_top: output-stage pan delay, pseudo/true compositing, frame signatures
// assumes: pixel-port fields arrive retimed on clk_in by the multiplexer;
// the colour tables outside return translated colours LUT_LAT clocks later;
// vsync_n_in is an asynchronous pin.
//
// Function
// - sync, blank, overlay delayed zero to seven pixels
// - zero delay matches colour table latency exactly
// - each delay count adds exactly one pixel
// - bit three chooses overlay pan or follow
// - mode 00: select low true, zero pseudo true
// - mode 01: pseudo zero shows true, else pseudo
// - mode 10: select pin alone picks the source
// - mode 11: always pseudo colour
// - three 24-bit signatures restart on vsync rise
// - blanked pixels leave signatures unchanged
// - signatures read red, then green, then blue
// - earlier byte low, later byte high
// - ones start, xor word, tapped shift left
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/10ps
module ppc_top
    import ppc_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic [7:0]  pseudo_idx_in,
    input  wire logic        per_pixel_source_pin_in,
    input  wire logic        sync_in,
    input  wire logic        blank_in,
    input  wire logic [1:0]  ovl_in,
    input  wire logic [23:0] pseudo_rgb_in,
    input  wire logic [23:0] true_rgb_in,
    input  wire logic        vsync_n_in,
    input  wire logic [1:0]  reg_addr_in,
    input  wire logic [23:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [23:0] rgb_out,
    output logic             sync_out,
    output logic             blank_out,
    output logic      [1:0]  ovl_out,
    output logic      [23:0] reg_rdata_out
);
    // control registers
    logic [3:0]  pan_delay_ctrl;   // bit 3 overlay pan, bits 2:0 delay
    logic [1:0]  layer_merge_ctrl; // compositing mode
    ppc_chan_t   rd_chan;          // next signature channel to read
    ppc_chan_t   next_rd_chan;     // pointer after a signature read

    // delay lines, index 0 is one clock old
    logic [SB_DEPTH-1:0] sync_pipe;   // composite sync history
    logic [SB_DEPTH-1:0] blank_pipe;  // blank history
    logic [1:0]          ovl_pipe [SB_DEPTH]; // overlay history
    logic [7:0]          idx_pipe [LUT_LAT];  // pseudo index, table aligned
    logic [LUT_LAT-1:0]  sel_pipe;    // source pin, table aligned

    // taps and composite choice
    logic [3:0]  sb_tap;       // tap for sync and blank
    logic [3:0]  ovl_tap;      // tap for overlays
    logic        use_pseudo;   // composite picks the pseudo image
    logic [23:0] next_rgb;     // composited pixel

    // vsync pin synchroniser and edge detect
    logic        vs_meta;      // first stage, read only by vs_sync
    logic        vs_sync;      // second stage
    logic        vs_prev;      // last synchronised level
    logic        frame_start;  // rising edge of the vsync pin

    // signature feed
    logic [23:0] sig_sum [3];  // per channel signatures, red first
    logic [23:0] next_rdata;   // read mux

    // settle counter used only by the checks below
    logic [3:0]  cfg_age;

    // register writes steer the pan and composite logic
    // writes to the signature and status words are dropped
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pan_delay_ctrl   <= PAN_RST;
            layer_merge_ctrl <= MERGE_RST;
        end else if (reg_wr_in) begin
            if (reg_addr_in == ADDR_PAN) begin
                pan_delay_ctrl <= reg_wdata_in[3:0];
            end else if (reg_addr_in == ADDR_MERGE) begin
                layer_merge_ctrl <= reg_wdata_in[1:0];
            end
        end
    end

    // signature read pointer walks red, green, blue and wraps
    // a fourth read starts over at red
    always_comb begin
        case (rd_chan)
            CH_RED:   next_rd_chan = CH_GREEN;
            CH_GREEN: next_rd_chan = CH_BLUE;
            default:  next_rd_chan = CH_RED;
        endcase
    end

    // the pointer restarts with each frame so reads always open with red
    always_ff @(posedge clk_in) begin
        if (rst_in || frame_start) begin
            rd_chan <= CH_RED;
        end else if (reg_rd_in && reg_addr_in == ADDR_SIG) begin
            rd_chan <= next_rd_chan;
        end
    end

    // read data mux; unmapped bits read as zero
    // reads never wait; a signature read advances the pointer
    always_comb begin
        if (reg_addr_in == ADDR_PAN) begin
            next_rdata = {20'h00000, pan_delay_ctrl};
        end else if (reg_addr_in == ADDR_MERGE) begin
            next_rdata = {22'h000000, layer_merge_ctrl};
        end else if (reg_addr_in == ADDR_SIG) begin
            case (rd_chan)
                CH_RED:   next_rdata = sig_sum[0];
                CH_GREEN: next_rdata = sig_sum[1];
                default:  next_rdata = sig_sum[2];
            endcase
        end else begin
            next_rdata = {22'h000000, rd_chan};
        end
    end

    // read data stand only in the cycle after the strobe
    // zero between reads keeps stale signatures off the port
    always_ff @(posedge clk_in) begin
        if (rst_in || !reg_rd_in) begin
            reg_rdata_out <= 24'h000000;
        end else begin
            reg_rdata_out <= next_rdata;
        end
    end

    // sync and blank history; long enough for the largest pan
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sync_pipe  <= '0;
            blank_pipe <= '1; // start blanked so nothing counts
        end else begin
            sync_pipe  <= {sync_pipe[SB_DEPTH-2:0], sync_in};
            blank_pipe <= {blank_pipe[SB_DEPTH-2:0], blank_in};
        end
    end

    // overlay history, one stage per entry
    for (genvar k = 0; k < SB_DEPTH; k++) begin : g_ovl
        always_ff @(posedge clk_in) begin
            if (rst_in) begin
                ovl_pipe[k] <= 2'h0;
            end else if (k == 0) begin
                ovl_pipe[k] <= ovl_in;
            end else begin
                // clamped index keeps the unused entry-0 branch in range
                ovl_pipe[k] <= ovl_pipe[(k == 0) ? 0 : k - 1];
            end
        end
    end

    // pseudo index and source pin held until the translated colours return
    for (genvar k = 0; k < LUT_LAT; k++) begin : g_idx
        always_ff @(posedge clk_in) begin
            if (rst_in) begin
                idx_pipe[k] <= 8'h00;
                sel_pipe[k] <= 1'b0;
            end else if (k == 0) begin
                idx_pipe[k] <= pseudo_idx_in;
                sel_pipe[k] <= per_pixel_source_pin_in;
            end else begin
                // clamped index keeps the unused entry-0 branch in range
                idx_pipe[k] <= idx_pipe[(k == 0) ? 0 : k - 1];
                sel_pipe[k] <= sel_pipe[(k == 0) ? 0 : k - 1];
            end
        end
    end

    // tap choice: count zero lines up with the table output stage
    // the largest tap is SB_DEPTH-1, so no index runs off the end;
    // overlays that pan keep the table latency only
    always_comb begin
        sb_tap = 4'(LUT_LAT - 1) + {1'b0, pan_delay_ctrl[2:0]};
        if (pan_delay_ctrl[PAN_OVL_BIT]) begin
            ovl_tap = 4'(LUT_LAT - 1);
        end else begin
            ovl_tap = sb_tap;
        end
    end

    // composite source choice per pixel
    // keying uses the raw index, not the translated colour
    always_comb begin
        case (layer_merge_ctrl)
            MERGE_KEY_SEL: begin
                use_pseudo = sel_pipe[LUT_LAT-1] && (idx_pipe[LUT_LAT-1] != 8'h00);
            end
            MERGE_KEY_ONLY: begin
                use_pseudo = (idx_pipe[LUT_LAT-1] != 8'h00);
            end
            MERGE_SEL_ONLY: begin
                use_pseudo = sel_pipe[LUT_LAT-1];
            end
            default: begin
                use_pseudo = 1'b1;
            end
        endcase
        next_rgb = use_pseudo ? pseudo_rgb_in : true_rgb_in;
    end

    // output stage, every output from a flip-flop
    // blank resets high so nothing reads as visible early
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rgb_out   <= 24'h000000;
            sync_out  <= 1'b0;
            blank_out <= 1'b1;
            ovl_out   <= 2'h0;
        end else begin
            rgb_out   <= next_rgb;
            sync_out  <= sync_pipe[sb_tap];
            blank_out <= blank_pipe[sb_tap];
            ovl_out   <= ovl_pipe[ovl_tap];
        end
    end

    // vsync pin: two flops before anything looks at it
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            // idle level of the pin is high: the release of reset
            // must not look like a frame start
            vs_meta <= 1'b1;
            vs_sync <= 1'b1;
            vs_prev <= 1'b1;
        end else begin
            vs_meta <= vsync_n_in;
            vs_sync <= vs_meta;
            vs_prev <= vs_sync;
        end
    end

    // frame restart on the rising pin level; host must read before this
    // a restart wins over a pointer step in the same cycle
    assign frame_start = vs_sync && !vs_prev;

    // one signature per channel; bytes are the converter values, so
    // the pan setting changes which pixels count as visible
    // all three channels share one clear and one take
    for (genvar c = 0; c < 3; c++) begin : g_sig
        ppc_sig_if sig_if ();
        assign sig_if.clear = frame_start;
        assign sig_if.take  = !blank_out;
        assign sig_if.data  = rgb_out[23-8*c -: 8];
        assign sig_sum[c]   = sig_if.sum;
        ppc_sig_acc u_acc (
            .clk_in (clk_in),
            .rst_in (rst_in),
            .sig    (sig_if.sink)
        );
    end

    // age of the last configuration write, saturating
    // CFG_SETTLED covers the longest history a check looks back on
    always_ff @(posedge clk_in) begin
        if (rst_in || reg_wr_in) begin
            cfg_age <= 4'h0;
        end else if (cfg_age != CFG_SETTLED) begin
            cfg_age <= cfg_age + 4'h1;
        end
    end

    // pan checks wait for cfg_age, so a fresh write
    // never meets a half-filled tap history
    pan_zero_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (cfg_age == CFG_SETTLED && pan_delay_ctrl[2:0] == 3'h0)
        |-> blank_out == $past(blank_in, 3) && sync_out == $past(sync_in, 3))
        else $error("zero pan does not match table latency");

    pan_one_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (cfg_age == CFG_SETTLED && pan_delay_ctrl[2:0] == 3'h1)
        |-> blank_out == $past(blank_in, 4))
        else $error("pan of one is not one pixel");

    pan_max_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (cfg_age == CFG_SETTLED && pan_delay_ctrl[2:0] == 3'h7)
        |-> sync_out == $past(sync_in, 10))
        else $error("pan of seven is not seven pixels");

    ovl_pan_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (cfg_age == CFG_SETTLED && pan_delay_ctrl[PAN_OVL_BIT])
        |-> ovl_out == $past(ovl_in, 3))
        else $error("panning overlay not aligned with picture");

    ovl_follow_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (cfg_age == CFG_SETTLED && pan_delay_ctrl == 4'h5)
        |-> ovl_out == $past(ovl_in, 8))
        else $error("overlay not following sync delay");

    // compositing: pin and index three clocks back,
    // colours one clock back
    key_sel_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (cfg_age == CFG_SETTLED && layer_merge_ctrl == MERGE_KEY_SEL)
        |-> rgb_out == (($past(per_pixel_source_pin_in, 3)
                         && $past(pseudo_idx_in, 3) != 8'h00)
                        ? $past(pseudo_rgb_in) : $past(true_rgb_in)))
        else $error("mode 00 picked the wrong source");

    key_only_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (cfg_age == CFG_SETTLED && layer_merge_ctrl == MERGE_KEY_ONLY)
        |-> rgb_out == (($past(pseudo_idx_in, 3) != 8'h00)
                        ? $past(pseudo_rgb_in) : $past(true_rgb_in)))
        else $error("mode 01 picked the wrong source");

    sel_only_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (cfg_age == CFG_SETTLED && layer_merge_ctrl == MERGE_SEL_ONLY)
        |-> rgb_out == ($past(per_pixel_source_pin_in, 3)
                        ? $past(pseudo_rgb_in) : $past(true_rgb_in)))
        else $error("mode 10 picked the wrong source");

    pseudo_only_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (cfg_age == CFG_SETTLED && layer_merge_ctrl == MERGE_PSEUDO)
        |-> rgb_out == $past(pseudo_rgb_in))
        else $error("mode 11 did not show pseudo colour");

    // register read port and frame restart
    read_order_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (reg_rd_in && reg_addr_in == ADDR_SIG && rd_chan == CH_RED && !frame_start)
        |=> rd_chan == CH_GREEN && reg_rdata_out == $past(sig_sum[0]))
        else $error("signature read out of order");

    frame_restart_a: assert property (@(posedge clk_in) disable iff (rst_in)
        frame_start |=> rd_chan == CH_RED && sig_sum[1] == SIG_INIT)
        else $error("frame start did not restart signatures");

    // scenarios the bench is meant to reach
    pan_cover_c: cover property (@(posedge clk_in) disable iff (rst_in)
        cfg_age == CFG_SETTLED && pan_delay_ctrl[2:0] == 3'h7 && $rose(blank_out));
    keyed_cover_c: cover property (@(posedge clk_in) disable iff (rst_in)
        layer_merge_ctrl == MERGE_KEY_SEL && sel_pipe[LUT_LAT-1] && !use_pseudo);
    read_cover_c: cover property (@(posedge clk_in) disable iff (rst_in)
        reg_rd_in && reg_addr_in == ADDR_SIG && rd_chan == CH_BLUE);
    frame_cover_c: cover property (@(posedge clk_in) disable iff (rst_in)
        frame_start ##1 !blank_out [*4]);
endmodule

// File: ppc_top_tb.sv
// ppc_top_tb: self-checking bench for the pan, composite and signature block
// assumes: ppc_pkg, ppc_sig_if, ppc_sig_acc, ppc_top and ppc_pix_src compiled
`timescale 1ns/10ps
module ppc_top_tb
    import ppc_pkg::*;
;
    typedef struct packed {
        logic [7:0]  idx;
        logic        sel;
        logic        sync;
        logic        blank;
        logic [1:0]  ovl;
        logic [23:0] prgb;
        logic [23:0] trgb;
    } ppc_hist_t;

    logic        clk_in, rst_in, vis_en, vsync_n, reg_wr, reg_rd, chk_en, half;
    logic [1:0]  reg_addr, cur_mode;
    logic [23:0] reg_wdata, rgb_out, reg_rdata_out, e_rgb;
    logic [7:0]  px_idx, b;
    logic        px_sel, px_sync, px_blank, sync_out, blank_out, e_blank;
    logic [1:0]  px_ovl, ovl_out, e_ovl;
    logic [23:0] px_prgb, px_trgb;
    logic [2:0]  cur_pan;      // expected delay count
    logic        cur_ovl;      // expected overlay pan bit
    ppc_hist_t   hist [0:10];  // pixel fields, index = cycles ago
    logic [23:0] exp_sum [0:2];
    logic [7:0]  low_b [0:2];  // earlier byte waiting for its partner
    int          n_errors, tests_run;

    ppc_pix_src src (.clk_in(clk_in), .rst_in(rst_in), .vis_en_in(vis_en),
        .idx_out(px_idx), .sel_out(px_sel), .sync_out(px_sync), .blank_out(px_blank),
        .ovl_out(px_ovl), .pseudo_rgb_out(px_prgb), .true_rgb_out(px_trgb));

    ppc_top dut (.clk_in(clk_in), .rst_in(rst_in), .pseudo_idx_in(px_idx),
        .per_pixel_source_pin_in(px_sel), .sync_in(px_sync), .blank_in(px_blank),
        .ovl_in(px_ovl), .pseudo_rgb_in(px_prgb), .true_rgb_in(px_trgb),
        .vsync_n_in(vsync_n), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
        .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .rgb_out(rgb_out), .sync_out(sync_out),
        .blank_out(blank_out), .ovl_out(ovl_out), .reg_rdata_out(reg_rdata_out));

    // 100 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // one signature step: fold the word in, then tapped shift left
    function automatic logic [23:0] sig_step(input logic [23:0] s, input logic [15:0] w);
        logic [23:0] t;
        t = s ^ {8'h00, w};
        if (!t[SIG_TOP]) begin
            t = ((t ^ SIG_TAP) << 1) | 24'h000001;
        end else begin
            t = t << 1;
        end
        return t;
    endfunction

    // compositing choice for one pixel
    function automatic logic [23:0] pick(input logic [1:0] m, input logic [7:0] ix,
        input logic s, input logic [23:0] p, input logic [23:0] t);
        case (m)
            MERGE_KEY_SEL:  return (s && ix != 8'h00) ? p : t;
            MERGE_KEY_ONLY: return (ix != 8'h00) ? p : t;
            MERGE_SEL_ONLY: return s ? p : t;
            default:        return p;
        endcase
    endfunction

    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // register port: one-cycle strobes, read data stands one cycle later
    task automatic reg_write(input logic [1:0] a, input logic [23:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_in);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd_chk(input string what, input logic [1:0] a, input logic [23:0] exp);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_in);
        reg_rd   <= 1'b0;
        @(posedge clk_in);
        check(what, exp, reg_rdata_out);
    endtask

    // rising edge on the vertical sync pin, with time to pass the synchroniser
    task automatic frame_start();
        vsync_n <= 1'b0;
        repeat (4) @(posedge clk_in);
        vsync_n <= 1'b1;
        repeat (8) @(posedge clk_in);
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // monitor: history of pixel fields, expected outputs, running signatures
    always @(posedge clk_in) begin
        for (int i = 10; i > 0; i--) begin
            hist[i] = hist[i-1];
        end
        hist[0] = {px_idx, px_sel, px_sync, px_blank, px_ovl, px_prgb, px_trgb};
        e_rgb   = pick(cur_mode, hist[3].idx, hist[3].sel, hist[1].prgb, hist[1].trgb);
        e_blank = hist[3+cur_pan].blank;
        e_ovl   = cur_ovl ? hist[3].ovl : hist[3+cur_pan].ovl;
        if (chk_en) begin
            check("rgb_out", e_rgb, rgb_out);
            check("sync_out", {23'h0, hist[3+cur_pan].sync}, {23'h0, sync_out});
            check("blank_out", {23'h0, e_blank}, {23'h0, blank_out});
            check("ovl_out", {22'h0, e_ovl}, {22'h0, ovl_out});
            // only visible bytes count, paired earlier-low
            if (!e_blank) begin
                for (int c = 0; c < 3; c++) begin
                    b = e_rgb[8*(2-c) +: 8];
                    if (half) begin
                        exp_sum[c] = sig_step(exp_sum[c], {b, low_b[c]});
                    end else begin
                        low_b[c] = b;
                    end
                end
                half = ~half;
            end
        end
    end

    // watchdog: the tests need about a thousand cycles
    initial begin
        repeat (20000) @(posedge clk_in);
        n_errors++;
        test_done();
    end

    initial begin
        rst_in = 1'b1; vis_en = 1'b0; vsync_n = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0;
        reg_addr = 2'h0; reg_wdata = 24'h000000; chk_en = 1'b0; half = 1'b0;
        cur_pan = 3'h0; cur_ovl = 1'b0; cur_mode = 2'h0;
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        // reset values and read-only places
        rd_chk("pan", ADDR_PAN, 24'h000000);
        rd_chk("merge", ADDR_MERGE, 24'h000000);
        reg_write(ADDR_SIG, 24'h123456);
        for (int i = 0; i < 3; i++) rd_chk("sig", ADDR_SIG, SIG_INIT);
        rd_chk("pointer", ADDR_STAT, 24'h000000);
        $display("test reset done, mismatches %0d", n_errors);
        // every compositing mode against a running stream
        vis_en <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            reg_write(ADDR_MERGE, 24'hfffffc | 24'(m));
            cur_mode = 2'(m);
            rd_chk("merge", ADDR_MERGE, 24'(m));
            repeat (12) @(posedge clk_in);
            chk_en = 1'b1;
            repeat (40) @(posedge clk_in);
            chk_en = 1'b0;
        end
        $display("test modes done, mismatches %0d", n_errors);
        // every pan count with both overlay choices
        for (int p = 0; p < 16; p++) begin
            reg_write(ADDR_PAN, 24'(p));
            cur_pan = 3'(p);
            cur_ovl = p[3];
            repeat (12) @(posedge clk_in);
            chk_en = 1'b1;
            repeat (24) @(posedge clk_in);
            chk_en = 1'b0;
        end
        $display("test pan done, mismatches %0d", n_errors);
        // one frame of signatures, read in flyback
        reg_write(ADDR_PAN, 24'h000003);
        cur_pan = 3'h3;
        cur_ovl = 1'b0;
        vis_en <= 1'b0;
        repeat (16) @(posedge clk_in);
        frame_start();
        for (int c = 0; c < 3; c++) exp_sum[c] = SIG_INIT;
        half = 1'b0;
        chk_en = 1'b1;
        vis_en <= 1'b1;
        repeat (101) @(posedge clk_in);
        vis_en <= 1'b0;
        repeat (16) @(posedge clk_in);
        chk_en = 1'b0;
        rd_chk("sig red", ADDR_SIG, exp_sum[0]);
        rd_chk("sig green", ADDR_SIG, exp_sum[1]);
        rd_chk("sig blue", ADDR_SIG, exp_sum[2]);
        rd_chk("sig red again", ADDR_SIG, exp_sum[0]);
        rd_chk("pointer", ADDR_STAT, 24'h000001);
        frame_start();
        rd_chk("pointer", ADDR_STAT, 24'h000000);
        rd_chk("sig cleared", ADDR_SIG, SIG_INIT);
        $display("test signature done, mismatches %0d", n_errors);
        test_done();
    end
endmodule
